// ==== hw/motor_control_param_flags.sv ====
`timescale 1ns/1ps
module motor_control_param_flags
	import motor_param_pkg::*;
#(
	parameter logic [31:0] STEPPER_CUR_KP = 32'h00001000,
	parameter logic [31:0] STEPPER_CUR_KI = 32'h00000100,
	parameter logic [31:0] BLDC_CUR_KP = 32'h00002000,
	parameter logic [31:0] BLDC_CUR_KI = 32'h00000200
)
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire obj_req_s req,
	output obj_rsp_s rsp,
	input wire logic ctrl_restart,
	input wire logic fw_default_invert,
	input wire logic autosetup_start,
	input wire logic motor_type_valid,
	input wire logic motor_is_bldc,
	output gain_bank_t gains,
	output logic field_inverted,
	output logic new_params_active,
	output logic accel_ff_enable,
	output logic autosetup_required,
	output logic autosetup_busy,
	output logic autosetup_done
);

	// a zero proportional preset would leave auto setup with a dead current loop
	if (STEPPER_CUR_KP == 32'h0 || BLDC_CUR_KP == 32'h0)
	begin : g_bad_preset
		$error("motor preset proportional gains must be nonzero");
	end

	logic [7:0] field_inv_override;
	logic [7:0] keep_params;
	logic [7:0] param_set;
	autosetup_e as_state;
	autosetup_e next_as;

	// object decode
	wire is_gain_obj = req.index == OBJ_CTRL_GAINS;
	wire is_flag_obj = req.index == OBJ_DRIVE_FLAGS;
	wire hit_gain = is_gain_obj && req.sub >= SUB_FIRST_GAIN && req.sub <= SUB_LAST_GAIN;
	wire hit_flag = is_flag_obj && req.sub <= SUB_PARAM_SET;
	wire [2:0] gidx = 3'(req.sub - SUB_FIRST_GAIN);
	wire [7:0] wbyte = req.wdata[7:0];
	wire val_tri = wbyte == FLAG_OFF || wbyte == FLAG_ON || wbyte == FLAG_NEG;
	wire val_bin = wbyte == FLAG_OFF || wbyte == FLAG_ON;
	wire flag_val_ok = (req.sub == SUB_FIELD_INV) ? val_tri : val_bin;
	// gains are frozen while auto setup owns them, so host writes are refused then
	wire gain_wr_ok = hit_gain && !autosetup_busy;
	wire flag_wr_ok = hit_flag && req.sub != SUB_ENTRY_COUNT &&
		(req.sub == SUB_RESERVED || flag_val_ok);
	wire wr_ok = req.wr ? (hit_gain ? gain_wr_ok : flag_wr_ok) : (hit_gain || hit_flag);
	wire gain_wr = req_valid && req.wr && gain_wr_ok;
	wire flag_wr = req_valid && req.wr && flag_wr_ok;

	// read mux; INTEGER8 flags read sign extended
	wire [7:0] flag_byte =
		(req.sub == SUB_ENTRY_COUNT) ? FLAGS_ENTRY_COUNT :
		(req.sub == SUB_FIELD_INV) ? field_inv_override :
		(req.sub == SUB_KEEP_PARAMS) ? keep_params :
		(req.sub == SUB_PARAM_SET) ? param_set : 8'h00;
	wire [31:0] flag_rdata = (req.sub == SUB_ENTRY_COUNT) ? {24'h000000, flag_byte} :
		{{24{flag_byte[7]}}, flag_byte};
	wire [31:0] rd_data = hit_gain ? gains[gidx] : (hit_flag ? flag_rdata : 32'h00000000);

	// answer one cycle after every request
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			rsp <= '0;
		else
		begin
			rsp.ack <= req_valid;
			rsp.abort <= req_valid && !wr_ok;
			rsp.rdata <= (req_valid && !req.wr && wr_ok) ? rd_data : 32'h00000000;
		end
	end

	// motor-type preset loaded by auto setup only when gains are not kept
	wire as_apply = as_state == AS_APPLY && keep_params == FLAG_OFF;
	wire [31:0] preset_kp = motor_is_bldc ? BLDC_CUR_KP : STEPPER_CUR_KP;
	wire [31:0] preset_ki = motor_is_bldc ? BLDC_CUR_KI : STEPPER_CUR_KI;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NUM_GAINS; i++)
				gains[i] <= gain_preset(3'(i));
		end
		else if (as_apply)
		begin
			gains[G_FLUX_KP] <= preset_kp;
			gains[G_FLUX_KI] <= preset_ki;
			gains[G_TORQ_KP] <= preset_kp;
			gains[G_TORQ_KI] <= preset_ki;
		end
		else if (gain_wr)
			gains[gidx] <= req.wdata;
	end

	// reserved entry accepts writes but keeps reading zero
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			field_inv_override <= RST_FIELD_INV;
			keep_params <= RST_KEEP_PARAMS;
			param_set <= RST_PARAM_SET;
		end
		else if (flag_wr)
		begin
			if (req.sub == SUB_FIELD_INV)
				field_inv_override <= wbyte;
			if (req.sub == SUB_KEEP_PARAMS)
				keep_params <= wbyte;
			if (req.sub == SUB_PARAM_SET)
				param_set <= wbyte;
		end
	end

	// the stored override only reaches the motor at a restart
	wire next_field_inverted = (field_inv_override == FLAG_ON) ? 1'b0 :
		(field_inv_override == FLAG_NEG) ? 1'b1 : fw_default_invert;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			field_inverted <= 1'b0;
		else if (ctrl_restart)
			field_inverted <= next_field_inverted;
	end

	// restart that lands with auto setup completion still demands a new run
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			autosetup_required <= 1'b0;
		else if (ctrl_restart)
			autosetup_required <= 1'b1;
		else if (as_state == AS_APPLY)
			autosetup_required <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			new_params_active <= 1'b1;
			accel_ff_enable <= 1'b0;
		end
		else
		begin
			new_params_active <= param_set == FLAG_ON;
			// no direction term: the factor acts on deceleration as well
			accel_ff_enable <= gains[G_ACCEL_FF] != 32'h00000000;
		end
	end

	always_comb
	begin
		next_as = as_state;
		case (as_state)
			AS_IDLE:
				if (autosetup_start)
					next_as = AS_DETECT;
			AS_DETECT:
				if (motor_type_valid)
					next_as = AS_APPLY;
			AS_APPLY:
				next_as = AS_IDLE;
			default:
				next_as = AS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			as_state <= AS_IDLE;
			autosetup_busy <= 1'b0;
			autosetup_done <= 1'b0;
		end
		else
		begin
			as_state <= next_as;
			autosetup_busy <= next_as != AS_IDLE;
			autosetup_done <= as_state == AS_APPLY;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_flag_write(logic [7:0] sub, logic [7:0] val);
		req_valid && req.wr && is_flag_obj && req.sub == sub && wbyte == val;
	endsequence

	sequence s_apply_fresh;
		as_state == AS_APPLY && keep_params == FLAG_OFF && motor_is_bldc;
	endsequence

	sequence s_apply_keep;
		as_state == AS_APPLY && keep_params == FLAG_ON;
	endsequence

	a_field_forced_pos: assert property (
		ctrl_restart && field_inv_override == FLAG_ON |=> !field_inverted)
		else $error("forced positive field still inverted");

	a_field_forced_neg: assert property (
		ctrl_restart && field_inv_override == FLAG_NEG |=> field_inverted)
		else $error("forced inverted field not inverted");

	a_field_waits_restart: assert property (
		!ctrl_restart |=> $stable(field_inverted))
		else $error("field direction changed without restart");

	a_restart_needs_setup: assert property (
		ctrl_restart |=> autosetup_required)
		else $error("restart did not demand auto setup");

	a_preset_applied: assert property (
		s_apply_fresh |=> gains[G_FLUX_KP] == BLDC_CUR_KP && gains[G_TORQ_KI] == BLDC_CUR_KI)
		else $error("bldc preset not applied by auto setup");

	a_keep_untouched: assert property (
		s_apply_keep |=> $stable(gains))
		else $error("kept gains modified by auto setup");

	a_set_select: assert property (
		s_flag_write(SUB_PARAM_SET, FLAG_OFF) |=> ##1 !new_params_active)
		else $error("legacy parameter set not selected");

	a_accel_enable: assert property (
		gains[G_ACCEL_FF] == 32'h00000000 |=> !accel_ff_enable)
		else $error("acceleration feed forward active at zero factor");

	a_count_reads_four: assert property (
		req_valid && !req.wr && is_flag_obj && req.sub == SUB_ENTRY_COUNT
		|=> rsp.ack && !rsp.abort && rsp.rdata == 32'h00000004)
		else $error("drive flag entry count not four");

	a_count_read_only: assert property (
		req_valid && req.wr && is_flag_obj && req.sub == SUB_ENTRY_COUNT |=> rsp.abort)
		else $error("write to entry count not refused");

	a_vel_ff_written: assert property (
		req_valid && req.wr && is_gain_obj && req.sub == 8'h0b && !autosetup_busy
		|=> gains[G_VEL_FF] == $past(req.wdata))
		else $error("velocity feed forward write lost");

	a_field_default: assert property (
		ctrl_restart && field_inv_override == FLAG_OFF |=> field_inverted == $past(fw_default_invert))
		else $error("default field direction not applied at restart");

	a_field_bad_refused: assert property (
		req_valid && req.wr && is_flag_obj && req.sub == SUB_FIELD_INV && !val_tri
		|=> rsp.abort && $stable(field_inv_override))
		else $error("illegal field inversion value accepted");

	a_stepper_preset: assert property (
		as_state == AS_APPLY && keep_params == FLAG_OFF && !motor_is_bldc
		|=> gains[G_FLUX_KP] == STEPPER_CUR_KP && gains[G_TORQ_KI] == STEPPER_CUR_KI)
		else $error("stepper preset not applied by auto setup");

	a_bldc_preset_rest: assert property (
		s_apply_fresh |=> gains[G_FLUX_KI] == BLDC_CUR_KI && gains[G_TORQ_KP] == BLDC_CUR_KP)
		else $error("bldc preset incomplete");

	a_busy_refuses_gain: assert property (
		req_valid && req.wr && hit_gain && autosetup_busy |=> rsp.abort)
		else $error("gain write accepted during auto setup");

	a_busy_gains_frozen: assert property (
		autosetup_busy && as_state != AS_APPLY |=> $stable(gains))
		else $error("gains changed while auto setup detects");

	a_keep_bad_refused: assert property (
		req_valid && req.wr && is_flag_obj && req.sub == SUB_KEEP_PARAMS && !val_bin
		|=> rsp.abort && $stable(keep_params))
		else $error("illegal keep parameters value accepted");

	a_set_bad_refused: assert property (
		req_valid && req.wr && is_flag_obj && req.sub == SUB_PARAM_SET && !val_bin
		|=> rsp.abort && $stable(param_set))
		else $error("illegal parameter set value accepted");

	a_new_set_on: assert property (
		param_set == FLAG_ON |=> new_params_active)
		else $error("new parameter set not selected");

	a_accel_on: assert property (
		gains[G_ACCEL_FF] != 32'h00000000 |=> accel_ff_enable)
		else $error("acceleration feed forward off at nonzero factor");

	a_open_gains_kept: assert property (
		as_state == AS_APPLY |=> $stable(gains[G_OPEN_KP]) && $stable(gains[G_OPEN_KI]))
		else $error("open loop gains touched by auto setup");

	a_reserved_zero: assert property (
		req_valid && !req.wr && is_flag_obj && req.sub == SUB_RESERVED
		|=> rsp.ack && !rsp.abort && rsp.rdata == 32'h00000000)
		else $error("reserved flag entry not read as zero");

endmodule // motor_control_param_flags

// ==== hw/motor_param_pkg.sv ====
package motor_param_pkg;
	localparam logic [15:0] OBJ_CTRL_GAINS = 16'h3210;
	localparam logic [15:0] OBJ_DRIVE_FLAGS = 16'h3212;
	localparam logic [7:0] SUB_FIRST_GAIN = 8'h05;
	localparam logic [7:0] SUB_LAST_GAIN = 8'h0c;
	localparam logic [7:0] SUB_ENTRY_COUNT = 8'h00;
	localparam logic [7:0] SUB_RESERVED = 8'h01;
	localparam logic [7:0] SUB_FIELD_INV = 8'h02;
	localparam logic [7:0] SUB_KEEP_PARAMS = 8'h03;
	localparam logic [7:0] SUB_PARAM_SET = 8'h04;
	localparam logic [7:0] FLAGS_ENTRY_COUNT = 8'h04;
	localparam logic [7:0] FLAG_OFF = 8'h00;
	localparam logic [7:0] FLAG_ON = 8'h01;
	localparam logic [7:0] FLAG_NEG = 8'hff;
	localparam logic [7:0] RST_FIELD_INV = 8'h00;
	localparam logic [7:0] RST_KEEP_PARAMS = 8'h00;
	localparam logic [7:0] RST_PARAM_SET = 8'h01;
	localparam logic [31:0] RST_CUR_KP_CLOSED = 32'h00881ee0;
	localparam logic [31:0] RST_CUR_KI_CLOSED = 32'h0007c740;
	localparam logic [31:0] RST_CUR_KP_OPEN = 32'h004dc880;
	localparam logic [31:0] RST_CUR_KI_OPEN = 32'h001d2b30;
	localparam logic [31:0] RST_VEL_FF = 32'h000003e8;
	localparam logic [31:0] RST_ACCEL_FF = 32'h00000000;
	localparam int NUM_GAINS = 8;
	// gain bank slots, subindex minus first gain subindex
	localparam logic [2:0] G_FLUX_KP = 3'h0;
	localparam logic [2:0] G_FLUX_KI = 3'h1;
	localparam logic [2:0] G_TORQ_KP = 3'h2;
	localparam logic [2:0] G_TORQ_KI = 3'h3;
	localparam logic [2:0] G_OPEN_KP = 3'h4;
	localparam logic [2:0] G_OPEN_KI = 3'h5;
	localparam logic [2:0] G_VEL_FF = 3'h6;
	localparam logic [2:0] G_ACCEL_FF = 3'h7;

	typedef logic [NUM_GAINS-1:0][31:0] gain_bank_t;

	typedef struct packed {
		logic wr;
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] wdata;
	} obj_req_s;

	typedef struct packed {
		logic ack;
		logic abort;
		logic [31:0] rdata;
	} obj_rsp_s;

	typedef enum {AS_IDLE, AS_DETECT, AS_APPLY} autosetup_e;

	function automatic logic [31:0] gain_preset(input logic [2:0] slot);
		case (slot)
			G_FLUX_KP, G_TORQ_KP: gain_preset = RST_CUR_KP_CLOSED;
			G_FLUX_KI, G_TORQ_KI: gain_preset = RST_CUR_KI_CLOSED;
			G_OPEN_KP: gain_preset = RST_CUR_KP_OPEN;
			G_OPEN_KI: gain_preset = RST_CUR_KI_OPEN;
			G_VEL_FF: gain_preset = RST_VEL_FF;
			default: gain_preset = RST_ACCEL_FF;
		endcase
	endfunction
endpackage

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
module host_model
	import motor_param_pkg::*;
(
	input wire logic sys_clk,
	output logic req_valid,
	output obj_req_s req,
	output logic ctrl_restart,
	output logic autosetup_start,
	output logic motor_type_valid,
	output logic motor_is_bldc
);
	initial
	begin
		req_valid = 1'h0;
		req = '0;
		ctrl_restart = 1'h0;
		autosetup_start = 1'h0;
		motor_type_valid = 1'h0;
		motor_is_bldc = 1'h0;
	end
	task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
		@(negedge sys_clk);
		req_valid <= 1'h1;
		req <= '{w, i, s, d};
	endtask
	// released bus shows inverted leftovers so a stale sample cannot match
	task idle();
		@(negedge sys_clk);
		req_valid <= 1'h0;
		req <= ~req;
	endtask
	task pulse_restart();
		@(negedge sys_clk);
		ctrl_restart <= 1'h1;
		@(negedge sys_clk);
		ctrl_restart <= 1'h0;
	endtask
	// host reruns auto setup after a restart; detection may be slow
	task setup(input logic bldc, input int dly);
		@(negedge sys_clk);
		autosetup_start <= 1'h1;
		@(negedge sys_clk);
		autosetup_start <= 1'h0;
		repeat (dly) @(negedge sys_clk);
		motor_type_valid <= 1'h1;
		motor_is_bldc <= bldc;
		@(negedge sys_clk);
		motor_type_valid <= 1'h0;
	endtask
endmodule // host_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
	import motor_param_pkg::*;
	localparam logic [31:0] BKP = 32'h0000abcd;
	localparam logic [31:0] BKI = 32'h00001234;
	localparam logic [31:0] SKP = 32'h00003c3c;
	localparam logic [31:0] SKI = 32'h00000456;
	logic sys_clk, rstn, fw_default_invert, req_valid, ctrl_restart, autosetup_start;
	logic motor_type_valid, motor_is_bldc, field_inverted, new_params_active, accel_ff_enable;
	logic autosetup_required, autosetup_busy, autosetup_done;
	obj_req_s req;
	obj_rsp_s rsp;
	gain_bank_t gains;
	int failures = 0, cmp_count = 0, seed = 61;
	logic [32:0] exp_q[$];
	logic [31:0] v[8];
	logic [31:0] pre[8] = '{32'h00881ee0, 32'h0007c740, 32'h00881ee0, 32'h0007c740,
		32'h004dc880, 32'h001d2b30, 32'h000003e8, 32'h00000000};
	logic [31:0] fl[5] = '{32'h00000004, 32'h0, 32'h0, 32'h0, 32'h00000001};
	logic [7:0] fv[3] = '{8'hff, 8'h01, 8'h00};
	logic fe[3] = '{1'h1, 1'h0, 1'h1};

	motor_control_param_flags #(.BLDC_CUR_KP(BKP), .BLDC_CUR_KI(BKI), .STEPPER_CUR_KP(SKP),
		.STEPPER_CUR_KI(SKI)) u_dut (.sys_clk(sys_clk),
		.rstn(rstn), .req_valid(req_valid), .req(req), .rsp(rsp), .ctrl_restart(ctrl_restart),
		.fw_default_invert(fw_default_invert), .autosetup_start(autosetup_start),
		.motor_type_valid(motor_type_valid), .motor_is_bldc(motor_is_bldc), .gains(gains),
		.field_inverted(field_inverted), .new_params_active(new_params_active),
		.accel_ff_enable(accel_ff_enable), .autosetup_required(autosetup_required),
		.autosetup_busy(autosetup_busy), .autosetup_done(autosetup_done));
	host_model u_host (.sys_clk(sys_clk), .req_valid(req_valid), .req(req),
		.ctrl_restart(ctrl_restart), .autosetup_start(autosetup_start),
		.motor_type_valid(motor_type_valid), .motor_is_bldc(motor_is_bldc));

	task check(input string n, input logic [32:0] seen, input logic [32:0] expv);
		cmp_count++;
		if (seen !== expv)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, expv, seen);
		end
	endtask
	task results();
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
		input logic ab, input logic [31:0] e);
		u_host.acc(w, i, s, d);
		exp_q.push_back({ab, e});
	endtask
	task wait_done();
		int n;
		for (n = 0; n < 20; n++)
		begin
			@(negedge sys_clk);
			if (autosetup_done === 1'h1)
				break;
		end
		if (n == 20)
		begin
			failures++;
			results();
		end
	endtask

	always @(negedge sys_clk)
		if (rsp.ack === 1'h1)
		begin
			if (exp_q.size() == 0)
				check("rsp_extra", 33'h1, 33'h0);
			else
				check("rsp", {rsp.abort, rsp.rdata}, exp_q.pop_front());
		end

	initial
	begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		#500000;
		failures++;
		results();
	end

	initial
	begin
		rstn = 1'h0;
		fw_default_invert = 1'h1;
		repeat (4) @(negedge sys_clk);
		rstn = 1'h1;
		for (int k = 0; k < 8; k++)
			acc(1'h0, 16'h3210, 8'(k + 5), '0, 1'h0, pre[k]);
		for (int k = 0; k < 5; k++)
			acc(1'h0, 16'h3212, 8'(k), '0, 1'h0, fl[k]);
		// gain writes back to back, then read back
		for (int k = 0; k < 8; k++)
		begin
			v[k] = $random(seed);
			acc(1'h1, 16'h3210, 8'(k + 5), v[k], 1'h0, '0);
		end
		for (int k = 0; k < 8; k++)
			acc(1'h0, 16'h3210, 8'(k + 5), '0, 1'h0, v[k]);
		acc(1'h1, 16'h3212, 8'h00, 32'h5, 1'h1, '0);
		acc(1'h1, 16'h3212, 8'h02, 32'h5, 1'h1, '0);
		acc(1'h1, 16'h3212, 8'h03, 32'h2, 1'h1, '0);
		acc(1'h1, 16'h3212, 8'h04, 32'h2, 1'h1, '0);
		acc(1'h1, 16'h3210, 8'h0d, 32'h1, 1'h1, '0);
		acc(1'h0, 16'h3211, 8'h05, '0, 1'h1, '0);
		acc(1'h1, 16'h3212, 8'h01, 32'h7, 1'h0, '0);
		acc(1'h0, 16'h3212, 8'h01, '0, 1'h0, '0);
		acc(1'h1, 16'h3212, 8'h04, 32'h0, 1'h0, '0);
		u_host.idle();
		repeat (2) @(negedge sys_clk);
		for (int k = 0; k < 8; k++)
			check("gains", {1'h0, gains[k]}, {1'h0, v[k]});
		check("accel_ff", {32'h0, accel_ff_enable}, {32'h0, v[7] != 0});
		check("new_set", {32'h0, new_params_active}, 33'h0);
		for (int k = 0; k < 3; k++)
		begin
			acc(1'h1, 16'h3212, 8'h02, {24'h0, fv[k]}, 1'h0, '0);
			acc(1'h0, 16'h3212, 8'h02, '0, 1'h0, {{24{fv[k][7]}}, fv[k]});
			u_host.idle();
			repeat (2) @(negedge sys_clk);
			check("inv_hold", {32'h0, field_inverted}, {32'h0, !fe[k]});
			u_host.pulse_restart();
			check("inv", {32'h0, field_inverted}, {32'h0, fe[k]});
			check("required", {32'h0, autosetup_required}, 33'h1);
		end
		// override still 00: the firmware default now decides the direction
		fw_default_invert = 1'h0;
		u_host.pulse_restart();
		check("inv_default", {32'h0, field_inverted}, 33'h0);
		// gain write while busy must be refused, bldc preset applied
		fork
			u_host.setup(1'h1, 4);
			begin
				repeat (2) @(negedge sys_clk);
				acc(1'h1, 16'h3210, 8'h05, 32'h1, 1'h1, '0);
				check("busy", {32'h0, autosetup_busy}, 33'h1);
				u_host.idle();
			end
		join
		wait_done();
		check("busy", {32'h0, autosetup_busy}, 33'h0);
		for (int k = 0; k < 4; k++)
			check("as_gain", {1'h0, gains[k]}, {1'h0, k[0] ? BKI : BKP});
		check("required", {32'h0, autosetup_required}, 33'h0);
		acc(1'h1, 16'h3212, 8'h03, 32'h1, 1'h0, '0);
		acc(1'h1, 16'h3210, 8'h06, 32'h00000077, 1'h0, '0);
		u_host.idle();
		u_host.setup(1'h0, 1);
		wait_done();
		check("keep_gain", {1'h0, gains[1]}, 33'h77);
		check("keep_gain", {1'h0, gains[0]}, {1'h0, BKP});
		acc(1'h1, 16'h3212, 8'h03, 32'h0, 1'h0, '0);
		u_host.idle();
		u_host.setup(1'h0, 1);
		wait_done();
		for (int k = 0; k < 4; k++)
			check("step_gain", {1'h0, gains[k]}, {1'h0, k[0] ? SKI : SKP});
		// mid-run reset must bring every preset back
		@(negedge sys_clk);
		rstn = 1'h0;
		repeat (2) @(negedge sys_clk);
		rstn = 1'h1;
		repeat (2) @(negedge sys_clk);
		for (int k = 0; k < 8; k++)
			check("reset_gain", {1'h0, gains[k]}, {1'h0, pre[k]});
		check("reset_set", {32'h0, new_params_active}, 33'h1);
		check("rsp_left", 33'(exp_q.size()), 33'h0);
		results();
	end
endmodule // tb
